// *** rtl/scss_clock_select.sv ***
module scss_clock_select (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic external_clock_pin_i,
  input wire logic crystal_input_pin_i,
  input wire logic internal_osc_i,
  input wire logic wakeup_osc_i,
  input wire logic pll_clock_i,
  input wire logic [1:0] clock_source_select_i,
  input wire logic vco_bypass_i,
  input wire logic prescaler_source_i,
  input wire logic [scss_pkg::SCSS_DIV_W-1:0] output_prescaler_divider_i,
  output logic sys_clock_o,
  output scss_pkg::scss_mode_e active_mode_o,
  output logic switch_pending_o
);
  import scss_pkg::*;

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------

  // Mode from select code and bypass bit; code 01 is unused
  function automatic scss_mode_e decode_mode(input logic [1:0] sel, input logic bypass);
    scss_mode_e m;
    m = SCSS_MODE_WAKEUP;
    unique case (sel)
      SCSS_SEL_DIRECT: begin
        m = SCSS_MODE_DIRECT;
      end
      SCSS_SEL_PLL: begin
        if (bypass == SCSS_VCO_BYPASS_ON) begin
          m = SCSS_MODE_PRESCALE;
        end else begin
          m = SCSS_MODE_PLL;
        end
      end
      SCSS_SEL_WAKEUP: begin
        m = SCSS_MODE_WAKEUP;
      end
      default: begin
        m = SCSS_MODE_WAKEUP;
      end
    endcase
    return m;
  endfunction : decode_mode

  // Level of the source feeding the given mode
  function automatic logic pick_source(input scss_mode_e mode, input logic osc,
                                       input logic [SCSS_NUM_SRC-1:0] lv);
    logic s;
    s = 1'b0;
    unique case (mode)
      SCSS_MODE_DIRECT: begin
        s = lv[SCSS_SRC_EXT];
      end
      SCSS_MODE_PRESCALE: begin
        if (osc == SCSS_OSC_INTERNAL) begin
          s = lv[SCSS_SRC_INT];
        end else begin
          s = lv[SCSS_SRC_XTAL];
        end
      end
      SCSS_MODE_PLL: begin
        s = lv[SCSS_SRC_PLL];
      end
      SCSS_MODE_WAKEUP: begin
        s = lv[SCSS_SRC_WAKE];
      end
    endcase
    return s;
  endfunction : pick_source

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [SCSS_NUM_SRC-1:0] raw_pins;

  // Source pins gathered in bundle order
  always_comb begin
    raw_pins = '0;
    raw_pins[SCSS_SRC_EXT] = external_clock_pin_i;
    raw_pins[SCSS_SRC_XTAL] = crystal_input_pin_i;
    raw_pins[SCSS_SRC_INT] = internal_osc_i;
    raw_pins[SCSS_SRC_WAKE] = wakeup_osc_i;
    raw_pins[SCSS_SRC_PLL] = pll_clock_i;
  end

  // Bundle from synchroniser to selector
  scss_sync_if sync_bus ();

  // Three-flop capture of every source pin
  scss_pin_sync u_pin_sync (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .raw_i(raw_pins),
    .sync_bus(sync_bus.producer)
  );

  // ----------------------------------------------------------------
  // Selector state
  // ----------------------------------------------------------------
  typedef struct packed {
    scss_mode_e mode;
    logic osc_src;
    logic [SCSS_DIV_W-1:0] div;
    logic [SCSS_DIV_W-1:0] count;
    logic [SCSS_NUM_SRC-1:0] prev;
    logic sys_clk;
    logic pending;
  } scss_state_s;

  // Registered state and its next value
  scss_state_s st;
  scss_state_s next_st;

  // Synchronised source levels
  logic [SCSS_NUM_SRC-1:0] levels;
  assign levels = sync_bus.src_level;

  // ----------------------------------------------------------------
  // Requested configuration
  // ----------------------------------------------------------------
  scss_mode_e req_mode;
  logic req_osc;
  logic [SCSS_DIV_W-1:0] req_div;
  logic cfg_differs;

  // Requested configuration, only the fields that matter to its mode
  always_comb begin
    req_mode = decode_mode(clock_source_select_i, vco_bypass_i);
    req_osc = SCSS_RST_OSC;
    req_div = SCSS_RST_DIV;
    if (req_mode == SCSS_MODE_PRESCALE) begin
      req_osc = prescaler_source_i;
      req_div = output_prescaler_divider_i;
    end
  end

  // Request differs from the configuration in use
  assign cfg_differs = (req_mode != st.mode) || (req_osc != st.osc_src) || (req_div != st.div);

  // ----------------------------------------------------------------
  // Active source edge and divider geometry
  // ----------------------------------------------------------------
  logic act_level;
  logic act_prev;
  logic act_rise;
  logic [SCSS_DIV_W-1:0] eff_div;
  logic [SCSS_DIV_W:0] half_factor;
  logic at_wrap;
  logic switch_now;

  // Synchronised level of the source feeding the active mode
  assign act_level = pick_source(st.mode, st.osc_src, levels);
  assign act_prev = pick_source(st.mode, st.osc_src, st.prev);
  assign act_rise = act_level & ~act_prev;

  // Divider counts only in prescale mode, elsewhere the factor is one
  assign eff_div = (st.mode == SCSS_MODE_PRESCALE) ? st.div : '0;
  // Factor is divider plus one, up to 1024 with a 10-bit field
  assign half_factor = ({1'b0, eff_div} + 11'h002) >> 1;
  // Last source period of the output low phase
  assign at_wrap = (st.count == eff_div);

  // Switch once the request has stood a cycle, at end of a low phase
  assign switch_now = cfg_differs && st.pending && act_rise && at_wrap;

  // ----------------------------------------------------------------
  // Divider, pass-through and boundary switching
  // ----------------------------------------------------------------
  always_comb begin
    logic [SCSS_DIV_W-1:0] cnt;
    cnt = '0;
    next_st = st;
    // Count source rises, wrapping at the divider value
    cnt = st.count;
    if (act_rise) begin
      cnt = at_wrap ? '0 : st.count + 10'h001;
    end
    next_st.count = cnt;
    if (eff_div == '0) begin
      // High only from a rise, so a source already high is not cut short
      next_st.sys_clk = act_rise | (act_level & st.sys_clk);
    end else begin
      next_st.sys_clk = ({1'b0, cnt} < half_factor);
    end
    // Remember every source level for edge detection
    next_st.prev = levels;
    // Pending follows the request until a switch clears it
    next_st.pending = cfg_differs;
    // New path held low until its own first rise, so no runt pulse
    if (switch_now) begin
      next_st.mode = req_mode;
      next_st.osc_src = req_osc;
      next_st.div = req_div;
      next_st.count = req_div;
      next_st.sys_clk = 1'b0;
      next_st.pending = 1'b0;
    end
  end

  // State register
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st.mode <= SCSS_MODE_WAKEUP;
      st.osc_src <= SCSS_RST_OSC;
      st.div <= SCSS_RST_DIV;
      st.count <= SCSS_RST_DIV;
      st.prev <= SCSS_RST_LEVELS;
      st.sys_clk <= 1'b0;
      st.pending <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs straight from state flip-flops
  // ----------------------------------------------------------------
  assign sys_clock_o = st.sys_clk;
  assign active_mode_o = st.mode;
  assign switch_pending_o = st.pending;

endmodule : scss_clock_select

// *** inc/scss_pkg.sv ***
package scss_pkg;

  // ----------------------------------------------------------------
  // Configuration field codes
  // ----------------------------------------------------------------
  localparam int SCSS_DIV_W = 10;
  localparam int SCSS_MAX_FACTOR = 1024;
  localparam logic [1:0] SCSS_SEL_WAKEUP = 2'h0;
  localparam logic [1:0] SCSS_SEL_PLL = 2'h2;
  localparam logic [1:0] SCSS_SEL_DIRECT = 2'h3;
  localparam logic SCSS_VCO_BYPASS_ON = 1'h1;
  localparam logic SCSS_OSC_CRYSTAL = 1'h0;
  localparam logic SCSS_OSC_INTERNAL = 1'h1;

  // ----------------------------------------------------------------
  // Clock source positions in the synchronised bundle
  // ----------------------------------------------------------------
  localparam int SCSS_NUM_SRC = 5;
  localparam int SCSS_SRC_EXT = 0;
  localparam int SCSS_SRC_XTAL = 1;
  localparam int SCSS_SRC_INT = 2;
  localparam int SCSS_SRC_WAKE = 3;
  localparam int SCSS_SRC_PLL = 4;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [1:0] SCSS_RST_SEL = SCSS_SEL_WAKEUP;
  localparam logic SCSS_RST_BYPASS = 1'h0;
  localparam logic SCSS_RST_OSC = SCSS_OSC_CRYSTAL;
  localparam logic [SCSS_DIV_W-1:0] SCSS_RST_DIV = 10'h000;
  localparam logic [SCSS_NUM_SRC-1:0] SCSS_RST_LEVELS = 5'h00;

  // Operating modes of the system clock path
  typedef enum logic [1:0] {
    SCSS_MODE_WAKEUP,
    SCSS_MODE_PLL,
    SCSS_MODE_PRESCALE,
    SCSS_MODE_DIRECT
  } scss_mode_e;

endpackage : scss_pkg

// *** inc/scss_sync_if.sv ***
// Synchronised clock source levels, pin stage to selector
interface scss_sync_if;
  import scss_pkg::*;
  logic [SCSS_NUM_SRC-1:0] src_level;
  modport producer (output src_level);
  modport consumer (input src_level);
endinterface : scss_sync_if

// *** rtl/scss_pin_sync.sv ***
module scss_pin_sync (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [scss_pkg::SCSS_NUM_SRC-1:0] raw_i,
  scss_sync_if.producer sync_bus
);
  import scss_pkg::*;

  typedef struct packed {
    logic [SCSS_NUM_SRC-1:0] stage1;
    logic [SCSS_NUM_SRC-1:0] stage2;
    logic [SCSS_NUM_SRC-1:0] stage3;
    logic [SCSS_NUM_SRC-1:0] level;
  } scss_sync_s;

  scss_sync_s st;
  scss_sync_s next_st;

  // ----------------------------------------------------------------
  // Three-stage capture, level moves once stages two and three agree
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.stage1 = raw_i;
    next_st.stage2 = st.stage1;
    next_st.stage3 = st.stage2;
    for (int i = 0; i < SCSS_NUM_SRC; i++) begin
      if (st.stage2[i] == st.stage3[i]) begin
        next_st.level[i] = st.stage3[i];
      end
    end
  end

  // State register
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st <= '{default: SCSS_RST_LEVELS};
    end else begin
      st <= next_st;
    end
  end

  assign sync_bus.src_level = st.level;

endmodule : scss_pin_sync

// *** sim/scss_clock_select_checker.sv ***
module scss_clock_select_checker (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic external_clock_pin_i,
  input wire logic crystal_input_pin_i,
  input wire logic internal_osc_i,
  input wire logic wakeup_osc_i,
  input wire logic pll_clock_i,
  input wire logic [1:0] clock_source_select_i,
  input wire logic vco_bypass_i,
  input wire logic prescaler_source_i,
  input wire logic [scss_pkg::SCSS_DIV_W-1:0] output_prescaler_divider_i,
  input wire logic sys_clock_o,
  input wire scss_pkg::scss_mode_e active_mode_o,
  input wire logic switch_pending_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import scss_pkg::*;
  // ----
  // Clock path checks
  // ----
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  a_direct_follow: assert property ($rose(sys_clock_o) &&
    active_mode_o == SCSS_MODE_DIRECT |-> $past(external_clock_pin_i, 5)) else $error("direct");
  a_wake_follow: assert property ($rose(sys_clock_o) &&
    active_mode_o == SCSS_MODE_WAKEUP |-> $past(wakeup_osc_i, 5)) else $error("wakeup");
  a_pll_follow: assert property ($rose(sys_clock_o) &&
    active_mode_o == SCSS_MODE_PLL |-> $past(pll_clock_i, 5)) else $error("pll");
  a_switch_clean: assert property ($changed(active_mode_o) |->
    !sys_clock_o && !switch_pending_o && $past(switch_pending_o)) else $error("switch");
  a_direct_decode: assert property ($changed(active_mode_o) &&
    active_mode_o == SCSS_MODE_DIRECT |-> $past(clock_source_select_i) == SCSS_SEL_DIRECT)
    else $error("direct code");
  a_prescale_decode: assert property ($changed(active_mode_o) &&
    active_mode_o == SCSS_MODE_PRESCALE |-> $past(clock_source_select_i) == SCSS_SEL_PLL &&
    $past(vco_bypass_i)) else $error("prescale code");
  a_pll_decode: assert property ($changed(active_mode_o) &&
    active_mode_o == SCSS_MODE_PLL |-> $past(clock_source_select_i) == SCSS_SEL_PLL &&
    !$past(vco_bypass_i)) else $error("pll code");
  a_pending_rise: assert property ($changed(clock_source_select_i) &&
    clock_source_select_i[1] && active_mode_o == SCSS_MODE_WAKEUP |->
    ##[1:2] (switch_pending_o || $changed(active_mode_o))) else $error("pending");
endmodule : scss_clock_select_checker

// *** sim/scss_src_model.sv ***
module scss_src_model (
  output logic [scss_pkg::SCSS_NUM_SRC-1:0] src_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // High and low times in ns: ext, crystal, internal, wakeup, pll
  localparam int HI [5] = '{80, 60, 80, 280, 60};
  localparam int LO [5] = '{40, 140, 80, 280, 60};
  // Free-running oscillators, offset from the sampling edge
  for (genvar g = 0; g < 5; g++) begin : g_osc
    initial begin
      src_o[g] = 1'b0;
      #(3 + 4 * g);
      forever begin
        src_o[g] = 1'b1;
        #(HI[g]);
        src_o[g] = 1'b0;
        #(LO[g]);
      end
    end
  end
endmodule : scss_src_model

// *** sim/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import scss_pkg::*;
  localparam int LIM = 30000;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [1:0] clock_source_select_i = SCSS_SEL_WAKEUP;
  logic vco_bypass_i = 1'b0;
  logic prescaler_source_i = SCSS_OSC_CRYSTAL;
  logic [SCSS_DIV_W-1:0] output_prescaler_divider_i = 10'h000;
  logic [SCSS_NUM_SRC-1:0] src;
  logic sys_clock_o;
  scss_mode_e active_mode_o;
  logic switch_pending_o;
  int mismatches = 0;
  int checks = 0;
  int d;
  // Oscillators and block under test
  scss_src_model scss_src_model_inst (.src_o(src));
  scss_clock_select scss_clock_select_inst (
    .external_clock_pin_i(src[SCSS_SRC_EXT]),
    .crystal_input_pin_i(src[SCSS_SRC_XTAL]),
    .internal_osc_i(src[SCSS_SRC_INT]),
    .wakeup_osc_i(src[SCSS_SRC_WAKE]),
    .pll_clock_i(src[SCSS_SRC_PLL]),
    .*
  );
  always #10 mclk_i = ~mclk_i;
  // ----
  // Helpers
  // ----
  task automatic tick();
    @(posedge mclk_i);
    #1;
  endtask : tick
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_up(int n);
    if (n >= LIM) begin
      mismatches++;
      report_and_stop();
    end
  endtask : give_up
  task automatic wait_lvl(logic v, inout int n);
    while (sys_clock_o !== v && n < LIM) begin
      tick();
      n++;
    end
    give_up(n);
  endtask : wait_lvl
  // High time and period of one whole system clock cycle
  task automatic measure(output int hi, output int per);
    int n;
    n = 0;
    wait_lvl(1'b0, n);
    wait_lvl(1'b1, n);
    per = n;
    wait_lvl(1'b0, n);
    hi = n - per;
    wait_lvl(1'b1, n);
    per = n - per;
  endtask : measure
  function automatic int exp_hi(int dv, int h, int p);
    return (dv == 0) ? h : ((dv + 2) >> 1) * p;
  endfunction : exp_hi
  // Apply a configuration, await the switch, measure the result
  task automatic run(logic [1:0] s, logic b, logic o, int dv, scss_mode_e m, int h, int p);
    int hi;
    int per;
    int n;
    clock_source_select_i = s;
    vco_bypass_i = b;
    prescaler_source_i = o;
    output_prescaler_divider_i = 10'(dv);
    n = 0;
    tick();
    tick();
    while (switch_pending_o !== 1'b0 && n < LIM) begin
      tick();
      n++;
    end
    give_up(n);
    chk(32'(active_mode_o), 32'(m));
    measure(hi, per);
    measure(hi, per);
    chk(per, p);
    chk(hi, h);
  endtask : run
  // Main sequence, periods in mclk cycles
  initial begin
    void'($urandom(32'hC349));
    repeat (10) tick();
    chk(sys_clock_o, 1'b0);
    chk(32'(active_mode_o), 32'(SCSS_MODE_WAKEUP));
    chk(switch_pending_o, 1'b0);
    sys_rst_i = 1'b0;
    run(SCSS_SEL_WAKEUP, 1'b0, SCSS_OSC_CRYSTAL, 0, SCSS_MODE_WAKEUP, 14, 28);
    run(SCSS_SEL_DIRECT, 1'b0, SCSS_OSC_CRYSTAL, 0, SCSS_MODE_DIRECT, 4, 6);
    run(SCSS_SEL_PLL, 1'b0, SCSS_OSC_CRYSTAL, 0, SCSS_MODE_PLL, 3, 6);
    run(2'h1, 1'b0, SCSS_OSC_CRYSTAL, 0, SCSS_MODE_WAKEUP, 14, 28);
    run(SCSS_SEL_PLL, 1'b1, SCSS_OSC_CRYSTAL, 0, SCSS_MODE_PRESCALE, 3, 10);
    run(SCSS_SEL_PLL, 1'b1, SCSS_OSC_INTERNAL, 0, SCSS_MODE_PRESCALE, 4, 8);
    run(SCSS_SEL_PLL, 1'b1, SCSS_OSC_INTERNAL, 1, SCSS_MODE_PRESCALE, 8, 16);
    repeat (3) begin
      d = $urandom_range(40, 2);
      run(SCSS_SEL_PLL, 1'b1, SCSS_OSC_CRYSTAL, d, SCSS_MODE_PRESCALE,
          exp_hi(d, 3, 10), (d + 1) * 10);
    end
    run(SCSS_SEL_PLL, 1'b1, SCSS_OSC_INTERNAL, SCSS_MAX_FACTOR - 1, SCSS_MODE_PRESCALE,
        exp_hi(SCSS_MAX_FACTOR - 1, 4, 8), SCSS_MAX_FACTOR * 8);
    report_and_stop();
  end
endmodule : tb_top

bind scss_clock_select scss_clock_select_checker scss_clock_select_checker_inst (.*);
